// ===== rtl/mprs_defines.vh
// register offsets, field positions and reset values of the peak and region status bank
`ifndef MPRS_DEFINES_VH
`define MPRS_DEFINES_VH

// register indices as printed; byte address is four times the index
`define MPRS_IDX_A_REGION     12'h21d
`define MPRS_IDX_B_REGION     12'h23d
`define MPRS_IDX_C_REGION     12'h25d
`define MPRS_IDX_PEAK_CURRENT_CAPTURE        12'h400
`define MPRS_IDX_PEAK_VOLTAGE_CAPTURE        12'h401
`define MPRS_IDX_MAIN_CFG     12'h060
`define MPRS_IDX_AUX_CFG      12'h061
`define MPRS_IDX_REGION_IN    12'h062

`define MPRS_REGION_RESET     4'hf
`define MPRS_PEAK_RESET       24'h000000
`define MPRS_MULTIPOINT_COMP_ENABLE_BIT         4
`define MPRS_CURRENT_SUM_WAVEFORM_LSB         0
`define MPRS_PEAK_CHANNEL_SELECT_LSB      2
`define MPRS_PEAK_SHIFT       5
`define MPRS_PHASE_LSB        24

`define MPRS_CURRENT_SUM_WAVEFORM_ADD_N       2'h1
`define MPRS_CURRENT_SUM_WAVEFORM_SUB_N       2'h2

`endif

// ===== rtl/mprs_bank.v
// peak capture, region status and current-sum selection with an AXI4-Lite slave
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "mprs_defines.vh"

module mprs_bank #(
	parameter W = 32
) (
	input  wire          aclk,
	input  wire          aresetn,
	input  wire [12:0]   s_axi_awaddr,
	input  wire          s_axi_awvalid,
	output reg           s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output reg           s_axi_wready,
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	input  wire [12:0]   s_axi_araddr,
	input  wire          s_axi_arvalid,
	output reg           s_axi_arready,
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	input  wire          sample_valid,
	input  wire [W-1:0]  phase_a_current_wave,
	input  wire [W-1:0]  phase_b_current_wave,
	input  wire [W-1:0]  phase_c_current_wave,
	input  wire [W-1:0]  neutral_current_wave,
	input  wire [W-1:0]  phase_a_voltage_wave,
	input  wire [W-1:0]  phase_b_voltage_wave,
	input  wire [W-1:0]  phase_c_voltage_wave,
	output reg  [W-1:0]  current_sum_waveform,
	output reg           multipoint_comp_enable
);

// ----------------------------------------
// helpers
// ----------------------------------------
// byte address to printed index; misaligned addresses never match a register
// thirteen address bits are needed because the peak registers sit at index 0x400 and up
function [11:0] idx_of;
	input [12:0] a;
	begin
		idx_of = (a[1:0] == 2'h0) ? {1'b0, a[12:2]} : 12'hfff;
	end
endfunction

function [W-1:0] absv;
	input [W-1:0] v;
	begin
		absv = v[W-1] ? (~v + {{(W-1){1'b0}}, 1'b1}) : v;
	end
endfunction

// shifted magnitude, cut to the 24-bit peak field on purpose
function [23:0] mag_of;
	input [W-1:0] v;
	reg   [W-1:0] t;
	begin
		t = absv(v) >> `MPRS_PEAK_SHIFT;
		mag_of = t[23:0];
	end
endfunction

// ----------------------------------------
// configuration registers
// ----------------------------------------
reg  [1:0]  current_sum_select;
reg  [2:0]  peak_channel_select;
reg  [11:0] regions_in_q;

// ----------------------------------------
// write channel
// ----------------------------------------
reg         aw_held_q;
reg  [12:0] aw_addr_q;
reg         w_held_q;
reg  [31:0] w_data_q;
reg  [3:0]  w_strb_q;
wire        wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
wire [11:0] wr_idx = idx_of(aw_addr_q);

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_held_q <= 1'b0;
		w_held_q <= 1'b0;
		aw_addr_q <= 13'h0000;
		w_data_q <= 32'h00000000;
		w_strb_q <= 4'h0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'h0;
		current_sum_select <= 2'h0;
		multipoint_comp_enable <= 1'b0;
		peak_channel_select <= 3'h0;
		regions_in_q <= 12'h000;
	end else begin
		s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready);
		s_axi_wready <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready);
		if (s_axi_awvalid & s_axi_awready) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end
		if (s_axi_wvalid & s_axi_wready) begin
			w_held_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
		if (wr_go) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= 2'h0;
			case (wr_idx)
			`MPRS_IDX_MAIN_CFG: begin
				if (w_strb_q[0]) begin
					current_sum_select <= w_data_q[`MPRS_CURRENT_SUM_WAVEFORM_LSB+1:`MPRS_CURRENT_SUM_WAVEFORM_LSB];
					multipoint_comp_enable <= w_data_q[`MPRS_MULTIPOINT_COMP_ENABLE_BIT];
				end
			end
			`MPRS_IDX_AUX_CFG: begin
				if (w_strb_q[0])
					peak_channel_select <= w_data_q[`MPRS_PEAK_CHANNEL_SELECT_LSB+2:`MPRS_PEAK_CHANNEL_SELECT_LSB];
			end
			`MPRS_IDX_REGION_IN: begin
				if (w_strb_q[0])
					regions_in_q[7:0] <= w_data_q[7:0];
				if (w_strb_q[1])
					regions_in_q[11:8] <= w_data_q[11:8];
			end
			`MPRS_IDX_A_REGION, `MPRS_IDX_B_REGION, `MPRS_IDX_C_REGION,
			`MPRS_IDX_PEAK_CURRENT_CAPTURE, `MPRS_IDX_PEAK_VOLTAGE_CAPTURE: begin
				s_axi_bresp <= 2'h2;
			end
			default: begin
				s_axi_bresp <= 2'h3;
			end
			endcase
		end else if (s_axi_bvalid & s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// ----------------------------------------
// current sum
// ----------------------------------------
wire [W-1:0] phase_sum = phase_a_current_wave + phase_b_current_wave + phase_c_current_wave;

always @(posedge aclk) begin
	if (!aresetn) begin
		current_sum_waveform <= {W{1'b0}};
	end else begin
		case (current_sum_select)
		`MPRS_CURRENT_SUM_WAVEFORM_ADD_N: current_sum_waveform <= phase_sum + neutral_current_wave;
		`MPRS_CURRENT_SUM_WAVEFORM_SUB_N: current_sum_waveform <= phase_sum - neutral_current_wave;
		default:          current_sum_waveform <= phase_sum;
		endcase
	end
end

// ----------------------------------------
// region codes
// ----------------------------------------
// the region selector itself lives in the gain datapath; its codes arrive via regions_in_q
// one register per phase, so each slice has a single driver
wire [11:0] region_q;
genvar g;
generate
	for (g = 0; g < 3; g = g + 1) begin : g_region
		reg [3:0] code_q;
		always @(posedge aclk) begin
			if (!aresetn)
				code_q <= `MPRS_REGION_RESET;
			else if (multipoint_comp_enable)
				code_q <= regions_in_q[4*g+3:4*g];
			else
				code_q <= `MPRS_REGION_RESET;
		end
		assign region_q[4*g+3:4*g] = code_q;
	end
endgenerate

// ----------------------------------------
// peak capture
// ----------------------------------------
reg  [23:0] ipk_q;
reg  [2:0]  iph_q;
reg  [23:0] vpk_q;
reg  [2:0]  vph_q;
reg  [23:0] imag [0:2];
reg  [23:0] vmag [0:2];
reg  [23:0] inew;
reg  [23:0] vnew;
reg  [2:0]  iflg;
reg  [2:0]  vflg;
integer k;

// magnitudes above the stored peak win; ties with the new maximum are all flagged
always @* begin
	imag[0] = mag_of(phase_a_current_wave);
	imag[1] = mag_of(phase_b_current_wave);
	imag[2] = mag_of(phase_c_current_wave);
	vmag[0] = mag_of(phase_a_voltage_wave);
	vmag[1] = mag_of(phase_b_voltage_wave);
	vmag[2] = mag_of(phase_c_voltage_wave);
	inew = 24'h000000;
	vnew = 24'h000000;
	iflg = 3'h0;
	vflg = 3'h0;
	for (k = 0; k < 3; k = k + 1) begin
		if (peak_channel_select[k] && imag[k] > inew)
			inew = imag[k];
		if (peak_channel_select[k] && vmag[k] > vnew)
			vnew = vmag[k];
	end
	for (k = 0; k < 3; k = k + 1) begin
		iflg[k] = peak_channel_select[k] && (imag[k] == inew);
		vflg[k] = peak_channel_select[k] && (vmag[k] == vnew);
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		ipk_q <= `MPRS_PEAK_RESET;
		iph_q <= 3'h0;
		vpk_q <= `MPRS_PEAK_RESET;
		vph_q <= 3'h0;
	end else if (sample_valid) begin
		if (inew > ipk_q) begin
			ipk_q <= inew;
			iph_q <= iflg;
		end
		if (vnew > vpk_q) begin
			vpk_q <= vnew;
			vph_q <= vflg;
		end
	end
end

// ----------------------------------------
// read channel
// ----------------------------------------
wire [11:0] rd_idx = idx_of(s_axi_araddr);

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= 2'h0;
	end else begin
		s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
		if (s_axi_arvalid & s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (rd_idx)
			`MPRS_IDX_A_REGION: s_axi_rdata <= {28'h0000000, region_q[3:0]};
			`MPRS_IDX_B_REGION: s_axi_rdata <= {28'h0000000, region_q[7:4]};
			`MPRS_IDX_C_REGION: s_axi_rdata <= {28'h0000000, region_q[11:8]};
			`MPRS_IDX_PEAK_CURRENT_CAPTURE:    s_axi_rdata <= {5'h00, iph_q, ipk_q};
			`MPRS_IDX_PEAK_VOLTAGE_CAPTURE:    s_axi_rdata <= {5'h00, vph_q, vpk_q};
			`MPRS_IDX_MAIN_CFG: s_axi_rdata <= {27'h0000000, multipoint_comp_enable,
				2'h0, current_sum_select};
			`MPRS_IDX_AUX_CFG:  s_axi_rdata <= {27'h0000000, peak_channel_select, 2'h0};
			`MPRS_IDX_REGION_IN: s_axi_rdata <= {20'h00000, regions_in_q};
			default: begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= 2'h3;
			end
			endcase
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

endmodule // mprs_bank

// ===== sim/mprs_bank_props.sv
// assertion checker of the peak and region status bank
`timescale 1ns/1ns
module mprs_bank_props #(parameter W = 32) (
	input wire aclk, aresetn, s_axi_awvalid, s_axi_awready,
	input wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, multipoint_comp_enable,
	input wire [12:0] s_axi_awaddr, s_axi_araddr,
	input wire [31:0] s_axi_wdata, s_axi_rdata,
	input wire [W-1:0] phase_a_current_wave, phase_b_current_wave,
	input wire [W-1:0] phase_c_current_wave, neutral_current_wave, current_sum_waveform
);
	// ---
	// shadows of config writes and read address
	// ---
	reg [1:0] sel_q;
	reg en_q;
	reg [12:0] ra_q;
	wire [W-1:0] ph = phase_a_current_wave + phase_b_current_wave + phase_c_current_wave;
	wire [W-1:0] pp = ph + neutral_current_wave;
	wire [W-1:0] pm = ph - neutral_current_wave;
	wire wcfg = s_axi_awvalid & s_axi_awready & (s_axi_awaddr == 13'h0180);
	wire rreg = ra_q == 13'h0874 || ra_q == 13'h08f4 || ra_q == 13'h0974;
	wire rpk = ra_q == 13'h1000 || ra_q == 13'h1004;
	always @(posedge aclk) begin
		if (!aresetn) begin
			sel_q <= 2'h0;
			en_q <= 1'b0;
		end else if (wcfg) begin
			sel_q <= s_axi_wdata[1:0];
			en_q <= s_axi_wdata[4];
		end
		if (s_axi_arvalid & s_axi_arready)
			ra_q <= s_axi_araddr;
	end
	// ---
	// properties
	// ---
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_SUM_ADD: assert property (sel_q == 2'h1 |=> current_sum_waveform == $past(pp))
		else $error("sum with neutral added wrong");
	AST_SUM_SUB: assert property (sel_q == 2'h2 |=> current_sum_waveform == $past(pm))
		else $error("sum with neutral subtracted wrong");
	AST_SUM_PH: assert property (sel_q[0] == sel_q[1] |=> current_sum_waveform == $past(ph))
		else $error("phase only sum wrong");
	AST_MULTIPOINT_COMP_ENABLE: assert property (wcfg |-> ##[1:3] multipoint_comp_enable == en_q)
		else $error("compensation enable not following config");
	AST_REG_HI: assert property (s_axi_rvalid && rreg |-> s_axi_rdata[31:4] == 28'h0)
		else $error("region upper bits not zero");
	AST_REG_OFF: assert property ($rose(s_axi_rvalid) && rreg && !multipoint_comp_enable |-> s_axi_rdata[3:0] == 4'hf)
		else $error("region code shown while disabled");
	AST_PK_RSV: assert property (s_axi_rvalid && rpk |-> s_axi_rdata[31:27] == 5'h0)
		else $error("peak reserved bits set");
	AST_PK_FLAG: assert property (s_axi_rvalid && rpk && s_axi_rdata[23:0] != 24'h0 |-> s_axi_rdata[26:24] != 3'h0)
		else $error("peak without phase flag");
	cover property (wcfg && s_axi_wdata[4]);
	cover property (s_axi_rvalid && rpk);
	cover property (sel_q == 2'h2);
endmodule // mprs_bank_props

bind mprs_bank mprs_bank_props #(.W(W)) mprs_bank_props_inst (.*);

// ===== sim/mprs_bank_tb.sv
// self-checking bench of the peak and region status bank
`timescale 1ns/1ns
`include "mprs_defines.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module mprs_bank_tb;
	reg aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	reg s_axi_arvalid = 0, s_axi_rready = 0, sample_valid = 0;
	reg [12:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	reg [3:0] s_axi_wstrb = 4'hf;
	reg [31:0] s_axi_wdata = 0, phase_a_current_wave = 0, phase_b_current_wave = 0, phase_c_current_wave = 0;
	reg [31:0] neutral_current_wave = 0, phase_a_voltage_wave = 0, phase_b_voltage_wave = 0, phase_c_voltage_wave = 0, d;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, multipoint_comp_enable;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata, current_sum_waveform;
	integer n_fail = 0, compares = 0, i;
	mprs_bank mprs_bank_inst (.*);
	function [12:0] ba(input [11:0] x); ba = {x[10:0], 2'b00}; endfunction
	initial forever #25 aclk = ~aclk;
	// ---
	// bus tasks; result left in d
	// ---
	task wr(input [12:0] a, input [31:0] v); begin
		@(posedge aclk);
		s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 0; d = s_axi_bresp;
	end endtask
	task rd(input [12:0] a); begin
		@(posedge aclk);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 0; d = s_axi_rdata; i = s_axi_rresp;
	end endtask
	task smp(input [31:0] a, b, c, x, y, z); begin
		@(posedge aclk);
		phase_a_current_wave <= a; phase_b_current_wave <= b; phase_c_current_wave <= c;
		phase_a_voltage_wave <= x; phase_b_voltage_wave <= y; phase_c_voltage_wave <= z; sample_valid <= 1;
		@(posedge aclk);
		sample_valid <= 0;
	end endtask
	task stop_test; begin
		if (n_fail == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end endtask
	// ---
	// scenarios
	// ---
	task t_reset; begin
		rd(ba(`MPRS_IDX_A_REGION)); `CHK(d, 32'hf)
		rd(ba(`MPRS_IDX_C_REGION)); `CHK(d, 32'hf)
		rd(ba(`MPRS_IDX_PEAK_CURRENT_CAPTURE)); `CHK(d, 32'h0)
		rd(ba(`MPRS_IDX_PEAK_VOLTAGE_CAPTURE)); `CHK(d, 32'h0)
		rd(ba(`MPRS_IDX_MAIN_CFG)); `CHK(d[1:0], 2'h0)
	end endtask
	task t_sum; integer k; begin
		// neutral driven to 0x10 after each select write, so the add and subtract forms differ from the phase-only sum
		for (k = 0; k < 4; k++) begin
			wr(ba(`MPRS_IDX_MAIN_CFG), k);
			phase_a_current_wave <= 1; phase_b_current_wave <= 2; phase_c_current_wave <= 4; neutral_current_wave <= 32'h10;
			repeat (2) @(posedge aclk);
			`CHK(current_sum_waveform, 32'h7 + (k == 1 ? 32'h10 : 0) - (k == 2 ? 32'h10 : 0))
			rd(ba(`MPRS_IDX_MAIN_CFG)); `CHK(d[1:0], k[1:0])
			neutral_current_wave <= 0;
		end
	end endtask
	task t_region; begin
		wr(ba(`MPRS_IDX_REGION_IN), 32'h240);
		rd(ba(`MPRS_IDX_B_REGION)); `CHK(d, 32'hf)
		wr(ba(`MPRS_IDX_MAIN_CFG), 32'h10);
		rd(ba(`MPRS_IDX_A_REGION)); `CHK(d, 32'h0)
		`CHK(multipoint_comp_enable, 1'b1)
		rd(ba(`MPRS_IDX_B_REGION)); `CHK(d, 32'h4)
		rd(ba(`MPRS_IDX_C_REGION)); `CHK(d, 32'h2)
		wr(ba(`MPRS_IDX_C_REGION), 0); `CHK(d[1:0], 2'h2)
		rd(13'h1ffc); `CHK(i[1:0], 2'h3)
		wr(ba(`MPRS_IDX_MAIN_CFG), 0);
		rd(ba(`MPRS_IDX_C_REGION)); `CHK(d, 32'hf)
	end endtask
	task t_peak; begin
		wr(ba(`MPRS_IDX_AUX_CFG), 32'h1c);
		smp(32'hffffe000, 32'h1000, 32'h2000, 32'h40, 32'h80, 32'hffffff80);
		rd(ba(`MPRS_IDX_PEAK_CURRENT_CAPTURE)); `CHK(d, 32'h05000100)
		rd(ba(`MPRS_IDX_PEAK_VOLTAGE_CAPTURE)); `CHK(d, 32'h06000004)
		wr(ba(`MPRS_IDX_AUX_CFG), 32'h04);
		smp(32'h4000, 32'h8000, 0, 32'h100, 32'h200, 0);
		rd(ba(`MPRS_IDX_PEAK_CURRENT_CAPTURE)); `CHK(d, 32'h01000200)
		rd(ba(`MPRS_IDX_PEAK_VOLTAGE_CAPTURE)); `CHK(d, 32'h01000008)
	end endtask
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		t_reset; t_sum; t_region; t_peak;
		stop_test;
	end
	initial begin
		#100000;
		n_fail++;
		stop_test;
	end
endmodule // mprs_bank_tb
